/* File: bench/bcr_chk.sv */
// Port-level assertions for the setup bank
`timescale 1ns/100ps
module bcr_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Watched ports
    input wire logic converterEnablePin,
    input wire logic thermalWarning,
    input wire logic strapSyncDirInput,
    input wire logic strapSpreadEnable,
    input bcr_pkg::bcr_ctrl_t ctrl,
    input wire logic [7:0] retryPortSetup
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Run and foldback gating
    chk_run_needs_pin: assert property (!converterEnablePin |=> !ctrl.converterRun)
        else $error("run with pin low");
    chk_run_rise_pin: assert property ($rose(ctrl.converterRun) |-> $past(converterEnablePin))
        else $error("run without pin");
    chk_fold_warn: assert property (ctrl.foldbackActive |-> $past(thermalWarning))
        else $error("foldback without warning");
    chk_fold_limit_step: assert property ($rose(ctrl.foldbackActive) && $past(ctrl.currentLimit)
        != 3'h0 |-> ctrl.currentLimit == $past(ctrl.currentLimit) - 3'h1)
        else $error("limit not lowered");
    // Decoded values in their tables
    chk_volt_table: assert property (!$past(srst) |-> ctrl.busVoltageMv inside
        {16'd5000, 16'd9000, 16'd12000, 16'd15000, 16'd18000})
        else $error("voltage off table");
    chk_khz_table: assert property (!$past(srst) |-> ctrl.switchingKhz inside {12'd2200,
        12'd1200, 12'd790, 12'd600, 12'd488, 12'd410, 12'd350, 12'd310})
        else $error("frequency off table");
    chk_gain_step: assert property (!$past(srst) |->
        (ctrl.cableMilliohm % 18 == 0) && (ctrl.cableMilliohm <= 10'd558))
        else $error("gain step wrong");
    // Straps land after reset release
    chk_strap_sync: assert property ($fell(srst) |-> ##3
        (ctrl.syncPinOutput == !strapSyncDirInput))
        else $error("sync strap wrong");
    chk_strap_spread: assert property ($fell(srst) |-> ##3
        (ctrl.spreadEnable == strapSpreadEnable))
        else $error("spread strap wrong");
    chk_rsv_zero: assert property (retryPortSetup[2] == 1'b0)
        else $error("reserved bit set");

    // Main scenarios
    cover property (ctrl.foldbackActive);
    cover property (ctrl.busVoltageMv == 16'd18000);
    cover property (ctrl.cableMilliohm == 10'd558);
endmodule

bind bcr_top bcr_chk bcr_chk_i (.ref_clk(ref_clk), .srst(srst),
    .converterEnablePin(converterEnablePin), .thermalWarning(thermalWarning),
    .strapSyncDirInput(strapSyncDirInput), .strapSpreadEnable(strapSpreadEnable),
    .ctrl(ctrl), .retryPortSetup(retryPortSetup));

/* File: bench/bcr_host.sv */
// Serial host model that configures the bank
`timescale 1ns/100ps
module bcr_host (
    // Clock
    input wire logic ref_clk,
    // Data wire and host pins
    input wire logic sdaLine,
    output logic scl = 1'b1,
    output logic sda = 1'b1
);
    // Third of a serial clock period
    task automatic hw;
        repeat (6) @(posedge ref_clk);
    endtask

    // Start, sda falls while scl high
    task automatic start;
        sda <= 1'b1;
        hw();
        scl <= 1'b1;
        hw();
        sda <= 1'b0;
        hw();
        scl <= 1'b0;
        hw();
    endtask

    // Stop, sda rises while scl high
    task automatic stop;
        sda <= 1'b0;
        hw();
        scl <= 1'b1;
        hw();
        sda <= 1'b1;
        hw();
    endtask

    // Nine bits msb first, ack slot last
    task automatic xfer(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--) begin
            sda <= o[k];
            hw();
            scl <= 1'b1;
            hw();
            i[k] = sdaLine;
            scl <= 1'b0;
            hw();
        end
        sda <= 1'b1;
    endtask
endmodule

/* File: bench/bcr_top_tb.sv */
// Self-checking bench of the setup bank
`timescale 1ns/100ps
`include "bcr_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module bcr_top_tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic pinE = 1'b1;
    logic warn = 1'b0;
    logic [7:0] ana = 8'h5a;
    logic hScl;
    logic hSda;
    logic sdaOut;
    logic sdaOe;
    bcr_pkg::bcr_ctrl_t ctrl;
    int checks = 0;
    int n_mismatch = 0;
    logic [15:0] mv [8] = '{16'd5000, 16'd9000, 16'd12000, 16'd15000, 16'd18000,
        16'd5000, 16'd5000, 16'd5000};
    logic [11:0] kz [8] = '{12'd2200, 12'd1200, 12'd790, 12'd600, 12'd488, 12'd410,
        12'd350, 12'd310};
    wire sdaLine = hSda & ~sdaOe;

    bcr_top bcr_top_i (.ref_clk(ref_clk), .srst(srst), .sclIn(hScl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .strapFrequency(3'h5), .strapSyncDirInput(1'b1),
        .strapSpreadEnable(1'b1), .converterEnablePin(pinE), .thermalWarning(warn),
        .eventSet0(ana), .eventSet1(ana), .eventSet2(ana), .attachStatus(ana),
        .pinStatus(ana), .loadCurrent(ana), .busVoltage(ana), .dieTemperature(ana),
        .measurementDone(1'b0), .ctrl(ctrl), .measurementStart(), .portErrorRequest(),
        .portResetRequest(), .configurationDone(), .retryPortSetup(),
        .currentTripMode());
    bcr_host bcr_host_i (.ref_clk(ref_clk), .sdaLine(sdaLine), .scl(hScl), .sda(hSda));

    // Register write and read
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r;
        bcr_host_i.start();
        bcr_host_i.xfer({`BCR_DEV_ADDR, 2'b01}, r);
        bcr_host_i.xfer({a, 1'b1}, r);
        bcr_host_i.xfer({d, 1'b1}, r);
        bcr_host_i.stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [8:0] r;
        bcr_host_i.start();
        bcr_host_i.xfer({`BCR_DEV_ADDR, 2'b01}, r);
        bcr_host_i.xfer({a, 1'b1}, r);
        bcr_host_i.start();
        bcr_host_i.xfer({`BCR_DEV_ADDR, 2'b11}, r);
        bcr_host_i.xfer(9'h1ff, r);
        d = r[8:1];
        bcr_host_i.stop();
    endtask
    task automatic tick;
        repeat (3) @(posedge ref_clk);
    endtask

    // Reset values and straps
    task automatic t_reset;
        logic [7:0] d;
        rd(8'h00, d);
        `CHK("setup0", 8'h23, d);
        rd(8'h01, d);
        `CHK("setup1", 8'ha0, d);
        `CHK("khz", 12'd410, ctrl.switchingKhz);
        `CHK("syncOut", 1'b0, ctrl.syncPinOutput);
        `CHK("spread", 1'b1, ctrl.spreadEnable);
        `CHK("run", 1'b1, ctrl.converterRun);
        $display("t_reset done");
    endtask

    // Every voltage code
    task automatic t_vsel;
        logic [7:0] d;
        for (int c = 0; c < 8; c++) begin
            wr(8'h00, {3'b001, c[2:0], 2'b00});
            `CHK("busMv", mv[c], ctrl.busVoltageMv);
            `CHK("syncOut", 1'b1, ctrl.syncPinOutput);
        end
        rd(8'h00, d);
        `CHK("setup0 back", 8'h3c, d);
        $display("t_vsel done");
    endtask

    // Every frequency code, gain codes up to 31
    task automatic t_fsw;
        logic [4:0] g;
        for (int c = 0; c < 8; c++) begin
            g = 5'(c * 4 + 3);
            wr(8'h01, {c[2:0], g});
            `CHK("khz", kz[c], ctrl.switchingKhz);
            `CHK("mohm", 10'(g * 18), ctrl.cableMilliohm);
        end
        $display("t_fsw done");
    endtask

    // Run is the AND of bit and pin
    task automatic t_run;
        wr(8'h00, 8'h00);
        `CHK("run bit off", 1'b0, ctrl.converterRun);
        wr(8'h00, 8'h20);
        @(posedge ref_clk);
        pinE <= 1'b0;
        tick();
        `CHK("run pin off", 1'b0, ctrl.converterRun);
        pinE <= 1'b1;
        tick();
        `CHK("run both", 1'b1, ctrl.converterRun);
        $display("t_run done");
    endtask

    // Foldback only while enabled
    task automatic t_fold;
        wr(8'h00, 8'h60);
        @(posedge ref_clk);
        warn <= 1'b1;
        tick();
        `CHK("fold", 1'b1, ctrl.foldbackActive);
        `CHK("ilim", 3'h6, ctrl.currentLimit);
        `CHK("advert", 2'h0, ctrl.advertCurrent);
        wr(8'h00, 8'h20);
        `CHK("fold off", 1'b0, ctrl.foldbackActive);
        `CHK("ilim off", 3'h7, ctrl.currentLimit);
        `CHK("advert off", 2'h1, ctrl.advertCurrent);
        warn <= 1'b0;
        $display("t_fold done");
    endtask

    // Reserved, unmapped and live reads
    task automatic t_rsv;
        logic [7:0] d;
        wr(8'h00, 8'hff);
        rd(8'h00, d);
        `CHK("setup0 rsv", 8'h7f, d);
        wr(8'h13, 8'h77);
        rd(8'h13, d);
        `CHK("unmapped", 8'h00, d);
        rd(8'h10, d);
        `CHK("load", 8'h5a, d);
        rd(8'h0e, d);
        `CHK("pinstat", 8'h02, d);
        $display("t_rsv done");
    endtask

    // Counts and verdict
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_mismatch++;
        test_done();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_vsel();
        t_fsw();
        t_run();
        t_fold();
        t_rsv();
        test_done();
    end
endmodule

/* File: rtl/bcr_decode.sv */
// Setup field decode and thermal foldback
`timescale 1ns/100ps
module bcr_decode (
    // Setup fields and conditions
    input bcr_pkg::bcr_config_t cfg,
    input wire logic converterEnablePin,
    input wire logic thermalWarning,
    // Decoded controls
    output bcr_pkg::bcr_ctrl_t ctrl
);
    // Output level in millivolts
    function automatic logic [15:0] voltMv(input logic [2:0] code);
        case (code)
            3'h1: voltMv = 16'd9000;
            3'h2: voltMv = 16'd12000;
            3'h3: voltMv = 16'd15000;
            3'h4: voltMv = 16'd18000;
            default: voltMv = 16'd5000;
        endcase
    endfunction

    // Switching frequency in kHz
    function automatic logic [11:0] freqKhz(input logic [2:0] code);
        case (code)
            3'h0: freqKhz = 12'd2200;
            3'h1: freqKhz = 12'd1200;
            3'h2: freqKhz = 12'd790;
            3'h3: freqKhz = 12'd600;
            3'h4: freqKhz = 12'd488;
            3'h5: freqKhz = 12'd410;
            3'h6: freqKhz = 12'd350;
            default: freqKhz = 12'd310;
        endcase
    endfunction

    // One step lower pull-up advertisement for codes 1 and 2, codes 0 and 3 kept
    function automatic logic [1:0] advertDown(input logic [1:0] code);
        case (code)
            2'h2: advertDown = 2'h1;
            2'h1: advertDown = 2'h0;
            default: advertDown = code;
        endcase
    endfunction

    // Combinational decode
    always_comb begin
        ctrl.foldbackActive = cfg.thermalFoldbackEnable & thermalWarning;
        ctrl.converterRun = cfg.converterEnableBit & converterEnablePin;
        ctrl.busVoltageMv = voltMv(cfg.busVoltageSelect);
        ctrl.syncPinOutput = ~cfg.syncDirInput;
        ctrl.spreadEnable = cfg.spreadEnable;
        ctrl.switchingKhz = freqKhz(cfg.switchingFrequencySelect);
        ctrl.cableMilliohm = 10'(cfg.gain) * 10'd18;
        ctrl.advertCurrent = cfg.advertCurrent;
        ctrl.currentLimit = cfg.currentLimit;
        if (ctrl.foldbackActive) begin
            ctrl.advertCurrent = advertDown(cfg.advertCurrent);
            ctrl.currentLimit = (cfg.currentLimit == 3'h0) ? 3'h0 :
                cfg.currentLimit - 3'h1;
        end
    end
endmodule

/* File: rtl/bcr_defs.svh */
// Register offsets, field positions, masks and reset values of the setup bank
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH

// Register offsets
`define BCR_OFS_SETUP0 8'h00
`define BCR_OFS_SETUP1 8'h01
`define BCR_OFS_SETUP2 8'h02
`define BCR_OFS_SETUP3 8'h03
`define BCR_OFS_SETUP4 8'h04
`define BCR_OFS_MEASREQ 8'h05
`define BCR_OFS_PORTREQ 8'h06
`define BCR_OFS_EVEN0 8'h07
`define BCR_OFS_EVEN1 8'h08
`define BCR_OFS_EVEN2 8'h09
`define BCR_OFS_EVFL0 8'h0a
`define BCR_OFS_EVFL1 8'h0b
`define BCR_OFS_EVFL2 8'h0c
`define BCR_OFS_ATTACH 8'h0d
`define BCR_OFS_PINSTAT 8'h0e
`define BCR_OFS_LOADI 8'h10
`define BCR_OFS_BUSV 8'h11
`define BCR_OFS_TEMP 8'h12

// Serial port device address (arbitrary value)
`define BCR_DEV_ADDR 7'h2a

// Field positions
`define BCR_POS_FOLDBACK 6
`define BCR_POS_CONV_EN 5
`define BCR_POS_VSEL 2
`define BCR_POS_SYNC_DIR 1
`define BCR_POS_SPREAD 0
`define BCR_POS_FSW 5
`define BCR_POS_GAIN 0
`define BCR_POS_ILIM 0
`define BCR_POS_ADVERT 0
`define BCR_POS_THM_WARN 3

// Implemented (writable or readable) bits
`define BCR_MSK_SETUP0 8'h7f
`define BCR_MSK_SETUP1 8'hff
`define BCR_MSK_SETUP2 8'h17
`define BCR_MSK_SETUP3 8'hfb
`define BCR_MSK_SETUP4 8'h01
`define BCR_MSK_MEASREQ 8'h01
`define BCR_MSK_EV0 8'hbf
`define BCR_MSK_EV1 8'h7f
`define BCR_MSK_EV2 8'h2e
`define BCR_MSK_ATTACH 8'h1d
`define BCR_MSK_PINSTAT 8'h03

// Reset values
`define BCR_RST_SETUP0 8'h20
`define BCR_RST_SETUP1 8'h00
`define BCR_RST_SETUP2 8'h17
`define BCR_RST_SETUP3 8'h21
`define BCR_RST_ZERO 8'h00

`endif

/* File: rtl/bcr_i2c_slave.sv */
// Serial register port: address, pointer, auto-increment writes and reads
`timescale 1ns/100ps
`include "bcr_defs.svh"
module bcr_i2c_slave (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Serial pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Register access
    output bcr_pkg::bcr_wr_t wr,
    output logic [7:0] rdAddr,
    input wire logic [7:0] rdData
);
    bcr_pkg::bcr_slave_t s_q, s_d;
    logic sclRise, sclFall, startCond, stopCond;

    // Edges, start and stop
    assign sclRise = sclIn & ~s_q.sclQ;
    assign sclFall = ~sclIn & s_q.sclQ;
    assign startCond = sclIn & s_q.sclQ & s_q.sdaQ & ~sdaIn;
    assign stopCond = sclIn & s_q.sclQ & ~s_q.sdaQ & sdaIn;

    // Next state of the port
    always_comb begin
        s_d = s_q;
        s_d.sclQ = sclIn;
        s_d.sdaQ = sdaIn;
        s_d.wr.stb = 1'b0;
        if (startCond) begin
            s_d.st = bcr_pkg::ST_ADDR;
            s_d.cnt = 3'h0;
            s_d.sdaOe = 1'b0;
        end else if (stopCond) begin
            s_d.st = bcr_pkg::ST_IDLE;
            s_d.sdaOe = 1'b0;
        end else begin
            case (s_q.st)
                bcr_pkg::ST_ADDR, bcr_pkg::ST_PTR, bcr_pkg::ST_WR: begin
                    if (sclRise) begin
                        s_d.shift = {s_q.shift[6:0], sdaIn};
                        s_d.cnt = s_q.cnt + 3'h1;
                        s_d.ackPhase = 1'b0;
                        if (s_q.cnt == 3'h7) begin
                            if (s_q.st == bcr_pkg::ST_ADDR) begin
                                s_d.rw = sdaIn;
                                s_d.st = (s_q.shift[6:0] == `BCR_DEV_ADDR) ?
                                    bcr_pkg::ST_ADDR_ACK : bcr_pkg::ST_IDLE;
                            end else if (s_q.st == bcr_pkg::ST_PTR) begin
                                s_d.ptr = {s_q.shift[6:0], sdaIn};
                                s_d.st = bcr_pkg::ST_PTR_ACK;
                            end else begin
                                s_d.wr.stb = 1'b1;
                                s_d.wr.addr = s_q.ptr;
                                s_d.wr.data = {s_q.shift[6:0], sdaIn};
                                s_d.ptr = s_q.ptr + 8'h01;
                                s_d.st = bcr_pkg::ST_WR_ACK;
                            end
                        end
                    end
                end
                bcr_pkg::ST_ADDR_ACK, bcr_pkg::ST_PTR_ACK, bcr_pkg::ST_WR_ACK: begin
                    if (sclFall) begin
                        if (!s_q.ackPhase) begin
                            s_d.sdaOe = 1'b1; // Pull low for acknowledge
                            s_d.ackPhase = 1'b1;
                        end else if (s_q.st == bcr_pkg::ST_ADDR_ACK && s_q.rw) begin
                            s_d.shift = rdData;
                            s_d.sdaOe = ~rdData[7];
                            s_d.ptr = s_q.ptr + 8'h01;
                            s_d.cnt = 3'h0;
                            s_d.st = bcr_pkg::ST_RD;
                        end else begin
                            s_d.sdaOe = 1'b0;
                            s_d.cnt = 3'h0;
                            s_d.st = (s_q.st == bcr_pkg::ST_ADDR_ACK) ?
                                bcr_pkg::ST_PTR : bcr_pkg::ST_WR;
                        end
                    end
                end
                bcr_pkg::ST_RD: begin
                    if (sclFall) begin
                        if (s_q.cnt == 3'h7) begin
                            s_d.sdaOe = 1'b0;
                            s_d.st = bcr_pkg::ST_RD_ACK;
                        end else begin
                            s_d.shift = {s_q.shift[6:0], 1'b0};
                            s_d.sdaOe = ~s_q.shift[6];
                            s_d.cnt = s_q.cnt + 3'h1;
                        end
                    end
                end
                bcr_pkg::ST_RD_ACK: begin
                    if (sclRise) begin
                        s_d.nack = sdaIn;
                    end else if (sclFall) begin
                        if (s_q.nack) begin
                            s_d.st = bcr_pkg::ST_IDLE;
                        end else begin
                            s_d.shift = rdData;
                            s_d.sdaOe = ~rdData[7];
                            s_d.ptr = s_q.ptr + 8'h01;
                            s_d.cnt = 3'h0;
                            s_d.st = bcr_pkg::ST_RD;
                        end
                    end
                end
                default: begin
                    s_d.st = bcr_pkg::ST_IDLE;
                    s_d.sdaOe = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.sclQ <= 1'b1;
            s_q.sdaQ <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign sdaOut = 1'b0; // Open drain: only ever pulls low
    assign sdaOe = s_q.sdaOe;
    assign wr = s_q.wr;
    assign rdAddr = s_q.ptr;
endmodule

/* File: rtl/bcr_pkg.sv */
// Types shared by the setup bank, its serial port and its decoder
package bcr_pkg;

    // Serial port states, gray along the write path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_PTR = 4'h2,
        ST_PTR_ACK = 4'h6,
        ST_WR = 4'h7,
        ST_WR_ACK = 4'h5,
        ST_RD = 4'h4,
        ST_RD_ACK = 4'hc
    } bcr_state_t;

    // One register write from the serial port
    typedef struct packed {
        logic stb;
        logic [7:0] addr;
        logic [7:0] data;
    } bcr_wr_t;

    // Serial port state
    typedef struct packed {
        bcr_state_t st;
        logic sclQ;
        logic sdaQ;
        logic [7:0] shift;
        logic [2:0] cnt;
        logic rw;
        logic ackPhase;
        logic nack;
        logic sdaOe;
        logic [7:0] ptr;
        bcr_wr_t wr;
    } bcr_slave_t;

    // Setup fields handed to the decoder
    typedef struct packed {
        logic thermalFoldbackEnable;
        logic converterEnableBit;
        logic [2:0] busVoltageSelect;
        logic syncDirInput;
        logic spreadEnable;
        logic [2:0] switchingFrequencySelect;
        logic [4:0] gain;
        logic [2:0] currentLimit;
        logic [1:0] advertCurrent;
    } bcr_config_t;

    // Decoded controls towards the converter
    typedef struct packed {
        logic converterRun;
        logic foldbackActive;
        logic [15:0] busVoltageMv;
        logic [11:0] switchingKhz;
        logic [9:0] cableMilliohm;
        logic syncPinOutput;
        logic spreadEnable;
        logic [2:0] currentLimit;
        logic [1:0] advertCurrent;
    } bcr_ctrl_t;

    // Register bank state
    typedef struct packed {
        logic [7:0] setup0;
        logic [7:0] setup1;
        logic [7:0] setup2;
        logic [7:0] setup3;
        logic [7:0] setup4;
        logic [7:0] measReq;
        logic [7:0] even0;
        logic [7:0] even1;
        logic [7:0] even2;
        logic [7:0] evfl0;
        logic [7:0] evfl1;
        logic [7:0] evfl2;
        logic strapPending;
        logic portErrReq;
        logic portRstReq;
        logic [7:0] rdData;
        bcr_ctrl_t ctrl;
    } bcr_bank_t;

endpackage

/* File: rtl/bcr_top.sv */
// Configuration register bank of the buck converter with charging-port control
//
// Overview of operation
// - Foldback enabled plus warning lowers limit, and advert codes 1 and 2
// - Converter enable bit resets one, ANDed with pin
// - Voltage select resets zero, decodes 5/9/12/15/18V
// - Sync direction bit: 0 output, 1 input, strapped
// - Spread spectrum enable bit, initial value from strap
// - Frequency field decodes 2200 down to 310 kHz
// - Gain code n selects n times 18 milliohm
`timescale 1ns/100ps
`include "bcr_defs.svh"
module bcr_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Serial register port
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Strap resistor and converter pin
    input wire logic [2:0] strapFrequency,
    input wire logic strapSyncDirInput,
    input wire logic strapSpreadEnable,
    input wire logic converterEnablePin,
    // Analog side conditions
    input wire logic thermalWarning,
    input wire logic [7:0] eventSet0,
    input wire logic [7:0] eventSet1,
    input wire logic [7:0] eventSet2,
    input wire logic [7:0] attachStatus,
    input wire logic [7:0] pinStatus,
    input wire logic [7:0] loadCurrent,
    input wire logic [7:0] busVoltage,
    input wire logic [7:0] dieTemperature,
    input wire logic measurementDone,
    // Converter controls
    output bcr_pkg::bcr_ctrl_t ctrl,
    output logic measurementStart,
    output logic portErrorRequest,
    output logic portResetRequest,
    output logic configurationDone,
    output logic [7:0] retryPortSetup,
    output logic currentTripMode
);
    bcr_pkg::bcr_bank_t b_q, b_d;
    bcr_pkg::bcr_wr_t wr;
    bcr_pkg::bcr_config_t cfg;
    bcr_pkg::bcr_ctrl_t ctrlNext;
    logic [7:0] rdAddr;
    logic [7:0] evTerm2;

    // Read multiplexer, unmapped reads zero
    function automatic logic [7:0] readReg(input bcr_pkg::bcr_bank_t b,
            input logic [7:0] a, input logic [7:0] att, input logic [7:0] pin,
            input logic [7:0] li, input logic [7:0] bv, input logic [7:0] tp);
        case (a)
            `BCR_OFS_SETUP0: readReg = b.setup0 & `BCR_MSK_SETUP0;
            `BCR_OFS_SETUP1: readReg = b.setup1 & `BCR_MSK_SETUP1;
            `BCR_OFS_SETUP2: readReg = b.setup2 & `BCR_MSK_SETUP2;
            `BCR_OFS_SETUP3: readReg = b.setup3 & `BCR_MSK_SETUP3;
            `BCR_OFS_SETUP4: readReg = b.setup4 & `BCR_MSK_SETUP4;
            `BCR_OFS_MEASREQ: readReg = b.measReq & `BCR_MSK_MEASREQ;
            `BCR_OFS_PORTREQ: readReg = `BCR_RST_ZERO;
            `BCR_OFS_EVEN0: readReg = b.even0 & `BCR_MSK_EV0;
            `BCR_OFS_EVEN1: readReg = b.even1 & `BCR_MSK_EV1;
            `BCR_OFS_EVEN2: readReg = b.even2 & `BCR_MSK_EV2;
            `BCR_OFS_EVFL0: readReg = b.evfl0 & `BCR_MSK_EV0;
            `BCR_OFS_EVFL1: readReg = b.evfl1 & `BCR_MSK_EV1;
            `BCR_OFS_EVFL2: readReg = b.evfl2 & `BCR_MSK_EV2;
            `BCR_OFS_ATTACH: readReg = att & `BCR_MSK_ATTACH;
            `BCR_OFS_PINSTAT: readReg = pin & `BCR_MSK_PINSTAT;
            `BCR_OFS_LOADI: readReg = li;
            `BCR_OFS_BUSV: readReg = bv;
            `BCR_OFS_TEMP: readReg = tp;
            default: readReg = `BCR_RST_ZERO;
        endcase
    endfunction

    // Masked field update of a setup register
    function automatic logic [7:0] mergeReg(input logic [7:0] old,
            input logic [7:0] data, input logic [7:0] msk);
        mergeReg = (old & ~msk) | (data & msk);
    endfunction

    // Serial register port
    bcr_i2c_slave u_port (
        .ref_clk(ref_clk),
        .srst(srst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .wr(wr),
        .rdAddr(rdAddr),
        .rdData(b_q.rdData)
    );

    // Setup fields towards the decoder
    always_comb begin
        cfg.thermalFoldbackEnable = b_q.setup0[`BCR_POS_FOLDBACK];
        cfg.converterEnableBit = b_q.setup0[`BCR_POS_CONV_EN];
        cfg.busVoltageSelect = b_q.setup0[`BCR_POS_VSEL +: 3];
        cfg.syncDirInput = b_q.setup0[`BCR_POS_SYNC_DIR];
        cfg.spreadEnable = b_q.setup0[`BCR_POS_SPREAD];
        cfg.switchingFrequencySelect = b_q.setup1[`BCR_POS_FSW +: 3];
        cfg.gain = b_q.setup1[`BCR_POS_GAIN +: 5];
        cfg.currentLimit = b_q.setup2[`BCR_POS_ILIM +: 3];
        cfg.advertCurrent = b_q.setup3[`BCR_POS_ADVERT +: 2];
    end

    // Field decoding and thermal foldback
    bcr_decode u_decode (
        .cfg(cfg),
        .converterEnablePin(converterEnablePin),
        .thermalWarning(thermalWarning),
        .ctrl(ctrlNext)
    );

    // Warning sets its own event
    assign evTerm2 = eventSet2 | (8'(thermalWarning) << `BCR_POS_THM_WARN);

    // Next state of the bank
    always_comb begin
        b_d = b_q;
        b_d.ctrl = ctrlNext;
        b_d.portErrReq = 1'b0;
        b_d.portRstReq = 1'b0;
        // Strap values are taken once, the cycle after reset release
        if (b_q.strapPending) begin
            b_d.strapPending = 1'b0;
            b_d.setup0[`BCR_POS_SYNC_DIR] = strapSyncDirInput;
            b_d.setup0[`BCR_POS_SPREAD] = strapSpreadEnable;
            b_d.setup1[`BCR_POS_FSW +: 3] = strapFrequency;
        end
        // Request ends when results update
        if (measurementDone) begin
            b_d.measReq = `BCR_RST_ZERO;
        end
        // Host writes, reserved bits dropped
        if (wr.stb) begin
            case (wr.addr)
                `BCR_OFS_SETUP0: b_d.setup0 = mergeReg(b_q.setup0, wr.data,
                    `BCR_MSK_SETUP0);
                `BCR_OFS_SETUP1: b_d.setup1 = mergeReg(b_q.setup1, wr.data,
                    `BCR_MSK_SETUP1);
                `BCR_OFS_SETUP2: b_d.setup2 = mergeReg(b_q.setup2, wr.data,
                    `BCR_MSK_SETUP2);
                `BCR_OFS_SETUP3: b_d.setup3 = mergeReg(b_q.setup3, wr.data,
                    `BCR_MSK_SETUP3);
                `BCR_OFS_SETUP4: b_d.setup4 = mergeReg(b_q.setup4, wr.data,
                    `BCR_MSK_SETUP4);
                `BCR_OFS_MEASREQ: b_d.measReq = b_q.measReq |
                    (wr.data & `BCR_MSK_MEASREQ);
                `BCR_OFS_PORTREQ: begin
                    b_d.portErrReq = wr.data[1];
                    b_d.portRstReq = wr.data[0];
                end
                `BCR_OFS_EVEN0: b_d.even0 = wr.data & `BCR_MSK_EV0;
                `BCR_OFS_EVEN1: b_d.even1 = wr.data & `BCR_MSK_EV1;
                `BCR_OFS_EVEN2: b_d.even2 = wr.data & `BCR_MSK_EV2;
                `BCR_OFS_EVFL0: b_d.evfl0 = b_q.evfl0 & ~wr.data;
                `BCR_OFS_EVFL1: b_d.evfl1 = b_q.evfl1 & ~wr.data;
                `BCR_OFS_EVFL2: b_d.evfl2 = b_q.evfl2 & ~wr.data;
                default: b_d.setup4 = b_q.setup4;
            endcase
        end
        // Event flags: a set in the clearing cycle wins
        b_d.evfl0 = b_d.evfl0 | (eventSet0 & `BCR_MSK_EV0);
        b_d.evfl1 = b_d.evfl1 | (eventSet1 & `BCR_MSK_EV1);
        b_d.evfl2 = b_d.evfl2 | (evTerm2 & `BCR_MSK_EV2);
        // Registered read data
        b_d.rdData = readReg(b_q, rdAddr, attachStatus, pinStatus, loadCurrent,
            busVoltage, dieTemperature);
    end

    // Bank registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            b_q <= '0;
            b_q.setup0 <= `BCR_RST_SETUP0;
            b_q.setup1 <= `BCR_RST_SETUP1;
            b_q.setup2 <= `BCR_RST_SETUP2;
            b_q.setup3 <= `BCR_RST_SETUP3;
            b_q.strapPending <= 1'b1;
        end else begin
            b_q <= b_d;
        end
    end

    // Registered outputs
    assign ctrl = b_q.ctrl;
    assign measurementStart = b_q.measReq[0];
    assign portErrorRequest = b_q.portErrReq;
    assign portResetRequest = b_q.portRstReq;
    assign configurationDone = b_q.setup4[0];
    assign retryPortSetup = b_q.setup3 & `BCR_MSK_SETUP3;
    assign currentTripMode = b_q.setup2[4];
endmodule
